// ===== rtl/csm_defines.svh
`ifndef CSM_DEFINES_SVH
`define CSM_DEFINES_SVH

// register addresses on the serial control port (15-bit address space)
`define CSM_ADDR_DIV_PHASE   15'h0129
`define CSM_ADDR_REF_COUNT   15'h012A
`define CSM_ADDR_SYNC_MODE   15'h01FF
`define CSM_ADDR_APP_MODE    15'h0200
`define CSM_ADDR_DECIMATION  15'h0201

// field positions
`define CSM_SYNC_MODE_BIT    0
`define CSM_IONLY_BIT        5
`define CSM_APP_MODE_MSB     3
`define CSM_DEC_MSB          3
`define CSM_CLR_COUNT_BIT    6

// reset values
`define CSM_RST_SYNC_MODE    1'h0
`define CSM_RST_IONLY        1'h0
`define CSM_RST_APP_MODE     4'h0
`define CSM_RST_DECIMATION   4'h0
`define CSM_RST_COUNT        8'h00
`define CSM_RST_PHASE        4'h0

// sync mode bit value that selects link synchronization
`define CSM_SYNC_LINK_VALUE  1'h1

`endif

// ===== rtl/csm_pkg.sv
package csm_pkg;

   // register bus request
   typedef struct packed {
      logic        wrEn;
      logic        rdEn;
      logic [14:0] addr;
      logic [7:0]  wdata;
   } csm_req_type;

   // reference capture event from the capture front end
   typedef struct packed {
      logic       valid;
      logic [3:0] phase;
   } csm_ref_type;

   // chip application modes
   typedef enum logic [3:0] {
      CSM_APP_FULL = 4'h0,
      CSM_APP_ONE  = 4'h1,
      CSM_APP_TWO  = 4'h2,
      CSM_APP_FOUR = 4'h3
   } csm_app_type;

   // reference action
   typedef enum logic {
      CSM_ACT_STAMP,
      CSM_ACT_LINK
   } csm_act_type;

endpackage : csm_pkg

// ===== rtl/csm_ref_counter.sv
`timescale 1ns/1ns
`include "csm_defines.svh"
module csm_ref_counter #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             srst,
   // control
   input  wire logic             clear,
   input  wire logic             event_in,
   // count
   output logic      [WIDTH-1:0] count
);
   import csm_pkg::*;

   // (R03) increments on captured event
   // (R05) wraps past maximum
   always_ff @(posedge core_clk) begin
      if (srst || clear) begin
         count <= '0;
      end else if (event_in) begin
         count <= count + 1'b1;
      end
   end
endmodule : csm_ref_counter

// ===== rtl/csm_decim_decode.sv
`timescale 1ns/1ns
module csm_decim_decode (
   // decimation code
   input  wire logic [3:0] code,
   // decoded ratio
   output logic      [5:0] ratio
);
   import csm_pkg::*;

   // (R16) code to ratio map
   always_comb begin
      unique case (code)
         4'h0:    ratio = 6'd1;
         4'h1:    ratio = 6'd2;
         4'h8:    ratio = 6'd3;
         4'h2:    ratio = 6'd4;
         4'h5:    ratio = 6'd5;
         4'h9:    ratio = 6'd6;
         4'h3:    ratio = 6'd8;
         4'h6:    ratio = 6'd10;
         4'hA:    ratio = 6'd12;
         4'h7:    ratio = 6'd15;
         4'h4:    ratio = 6'd16;
         4'hD:    ratio = 6'd20;
         4'hB:    ratio = 6'd24;
         4'hE:    ratio = 6'd30;
         4'hF:    ratio = 6'd40;
         default: ratio = 6'd48;
      endcase
   end
endmodule : csm_decim_decode

// ===== rtl/csm_chip_sync_mode.sv
// Function
// (R01) phase code counts half input cycles
// (R02) 0000 in phase, 0001 half cycle
// (R03) 8-bit read-only reference event counter
// (R04) counter cleared by 0x0120 bit 6
// (R05) counter wraps from 255 to 0
// (R06) host reads counter only capture disabled
// (R07) bit 0 selects link or timestamp
// (R08) link mode resets all dividers
// (R09) link mode divider phase change drops link
// (R10) system uses link mode for multichip
// (R11) timestamp mode leaves dividers, link, monitor
// (R12) timestamp mode marks coinciding sample
// (R13) bit 5 selects in-phase only output
// (R14) application mode resets to full bandwidth
// (R15) app modes enable 1, 2, 4 downconverters
// (R16) decimation codes map to ratios
// (R17) reserved bits read zero, writes ignored
// (R18) status updated in sample clock domain
`timescale 1ns/1ns
`include "csm_defines.svh"
module csm_chip_sync_mode (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 srst,
   // serial control port register access
   input  wire csm_pkg::csm_req_type req,
   output logic      [7:0]           rdata,
   output logic                      rvalid,
   // reference capture control bit from register 0x0120
   input  wire logic                 clearCountBit,
   // captured reference event with divider phase
   input  wire csm_pkg::csm_ref_type refIn,
   // sample path
   input  wire logic                 sampleValid,
   // divider and link control, sample mark and monitor pulse
   output logic                      dividerReset,
   output logic                      linkDrop,
   output logic                      sampleMark,
   output logic                      monitorRefPulse,
   // chip operating mode
   output logic      [3:0]           downconverterEnable,
   output logic                      inPhaseOnly,
   output logic      [3:0]           appMode,
   output logic      [3:0]           decimationCode,
   output logic      [5:0]           decimationRatio
);
   import csm_pkg::*;

   // configuration and status state
   logic        syncMode;
   logic        ionly;
   logic [3:0]  appModeReg;
   logic [3:0]  decReg;
   logic [3:0]  phaseReg;
   logic [7:0]  refCount;
   logic [3:0]  lastPhase;
   logic        phaseKnown;

   // address decode
   wire         hitPhase = (req.addr == `CSM_ADDR_DIV_PHASE);
   wire         hitCount = (req.addr == `CSM_ADDR_REF_COUNT);
   wire         hitSync  = (req.addr == `CSM_ADDR_SYNC_MODE);
   wire         hitApp   = (req.addr == `CSM_ADDR_APP_MODE);
   wire         hitDec   = (req.addr == `CSM_ADDR_DECIMATION);
   wire         linkMode = (syncMode == `CSM_SYNC_LINK_VALUE);
   wire         refEvent = refIn.valid;
   // (R09) phase change detect
   wire         phaseMove = refEvent && phaseKnown && (refIn.phase != lastPhase);

   // (R07) mode bit write
   always_ff @(posedge core_clk) begin
      if (srst) begin
         syncMode <= `CSM_RST_SYNC_MODE;
      end else if (req.wrEn && hitSync) begin
         syncMode <= req.wdata[`CSM_SYNC_MODE_BIT];
      end
   end

   // (R13) (R14) chip mode write, (R17) reserved bits dropped
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ionly      <= `CSM_RST_IONLY;
         appModeReg <= `CSM_RST_APP_MODE;
      end else if (req.wrEn && hitApp) begin
         ionly      <= req.wdata[`CSM_IONLY_BIT];
         appModeReg <= req.wdata[`CSM_APP_MODE_MSB:0];
      end
   end

   // (R16) decimation write
   always_ff @(posedge core_clk) begin
      if (srst) begin
         decReg <= `CSM_RST_DECIMATION;
      end else if (req.wrEn && hitDec) begin
         decReg <= req.wdata[`CSM_DEC_MSB:0];
      end
   end

   // (R01) (R02) (R18) capture divider phase on each event
   always_ff @(posedge core_clk) begin
      if (srst) begin
         phaseReg   <= `CSM_RST_PHASE;
         lastPhase  <= `CSM_RST_PHASE;
         phaseKnown <= 1'b0;
      end else if (refEvent) begin
         phaseReg   <= refIn.phase;
         lastPhase  <= refIn.phase;
         phaseKnown <= 1'b1;
      end
   end

   // (R03) (R04) (R05) event counter
   csm_ref_counter #(
      .WIDTH (8)
   ) u_count (
      .core_clk (core_clk),
      .srst     (srst),
      .clear    (clearCountBit),
      .event_in (refEvent),
      .count    (refCount)
   );

   // (R16) ratio decode
   csm_decim_decode u_dec (
      .code  (decReg),
      .ratio (decimationRatio)
   );

   // read data, (R17) reserved bits zero
   wire [7:0] next_rdata = hitPhase ? {4'h0, phaseReg} :
                           hitCount ? refCount :
                           hitSync  ? {7'h00, syncMode} :
                           hitApp   ? {2'h0, ionly, 1'h0, appModeReg} :
                           hitDec   ? {4'h0, decReg} : 8'h00;

   // registered read response
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata  <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         rdata  <= req.rdEn ? next_rdata : 8'h00;
         rvalid <= req.rdEn;
      end
   end

   // reference action outputs
   always_ff @(posedge core_clk) begin
      if (srst) begin
         dividerReset    <= 1'b0;
         linkDrop        <= 1'b0;
         sampleMark      <= 1'b0;
         monitorRefPulse <= 1'b0;
      end else begin
         // (R08) link mode resets dividers
         dividerReset    <= refEvent && linkMode;
         // (R09) drop link on phase change
         linkDrop        <= phaseMove && linkMode;
         // (R11) (R12) timestamp marks sample only
         sampleMark      <= refEvent && !linkMode && sampleValid;
         monitorRefPulse <= refEvent && linkMode;
      end
   end

   // (R15) downconverter enables from application mode
   always_comb begin
      unique case (appModeReg)
         CSM_APP_ONE:  downconverterEnable = 4'b0001;
         CSM_APP_TWO:  downconverterEnable = 4'b0011;
         CSM_APP_FOUR: downconverterEnable = 4'b1111;
         default:      downconverterEnable = 4'b0000;
      endcase
   end

   // mode outputs
   assign inPhaseOnly    = ionly;
   assign appMode        = appModeReg;
   assign decimationCode = decReg;
endmodule : csm_chip_sync_mode

// ===== verification/csm_host_model.sv
`timescale 1ns/1ns
module csm_host_model (
   // clock
   input wire logic            core_clk,
   // register request
   output csm_pkg::csm_req_type req
);
   import csm_pkg::*;
   task automatic access(input logic w, input logic [14:0] a, input logic [7:0] d);
      @(negedge core_clk);
      req = '{w, ~w, a, d};
      @(negedge core_clk);
      req = '{1'b0, 1'b0, ~a, ~d}; // released bus shows no stale value
   endtask : access
   // idle bus at start
   initial req = '0;
endmodule : csm_host_model

// ===== verification/csm_chip_sync_mode_assertions.sv
`timescale 1ns/1ns
module csm_chip_sync_mode_assertions (
   // clock and reset
   input wire logic                 core_clk,
   input wire logic                 srst,
   // watched ports
   input wire csm_pkg::csm_req_type req,
   input wire logic                 rvalid,
   input wire csm_pkg::csm_ref_type refIn,
   input wire logic                 sampleValid,
   input wire logic                 dividerReset,
   input wire logic                 linkDrop,
   input wire logic                 sampleMark,
   input wire logic                 monitorRefPulse,
   input wire logic [3:0]           downconverterEnable,
   input wire logic [3:0]           appMode,
   input wire logic                 inPhaseOnly
);
   import csm_pkg::*;
   // all checks on the core clock
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   AST_READ_ANSWER:
      assert property (req.rdEn |=> rvalid) else $error("read unanswered");
   AST_NO_EXTRA_READ:
      assert property (rvalid |-> $past(req.rdEn)) else $error("stray read answer");
   AST_DIV_CAUSE:
      assert property (dividerReset |-> $past(refIn.valid)) else $error("stray divider reset");
   AST_MARK_CAUSE:
      assert property (sampleMark |-> $past(refIn.valid && sampleValid)) else $error("stray mark");
   AST_ONE_ACTION:
      assert property (refIn.valid && sampleValid |=> dividerReset != sampleMark) else $error("bad action");
   AST_MONITOR:
      assert property (monitorRefPulse == dividerReset) else $error("monitor touched");
   AST_DROP:
      assert property (linkDrop |-> dividerReset) else $error("drop outside link mode");
   AST_APP_EN:
      assert property (downconverterEnable == (appMode == 4'h1 ? 4'h1 : appMode == 4'h2 ? 4'h3 :
         appMode == 4'h3 ? 4'hF : 4'h0)) else $error("bad enables");
   AST_RESET_MODE:
      assert property ($fell(srst) |-> appMode == 4'h0 && !inPhaseOnly) else $error("bad reset mode");
endmodule : csm_chip_sync_mode_assertions
bind csm_chip_sync_mode csm_chip_sync_mode_assertions chk (.core_clk(core_clk), .srst(srst), .req(req),
   .rvalid(rvalid), .refIn(refIn), .sampleValid(sampleValid), .dividerReset(dividerReset),
   .linkDrop(linkDrop), .sampleMark(sampleMark), .monitorRefPulse(monitorRefPulse),
   .downconverterEnable(downconverterEnable), .appMode(appMode), .inPhaseOnly(inPhaseOnly));

// ===== verification/csm_chip_sync_mode_test.sv
`timescale 1ns/1ns
module csm_chip_sync_mode_test;
   import csm_pkg::*;
   // bench state
   logic        core_clk;
   logic        srst;
   logic        clr;
   logic        sampleValid;
   csm_req_type req;
   csm_ref_type refIn;
   logic [7:0]  rdata;
   logic        rvalid;
   logic [3:0]  dcEn;
   logic [5:0]  ratio;
   logic [3:0]  decCode;
   logic        ionlyOut;
   logic [7:0]  r;
   logic [7:0]  expQ[$];
   int          n_mismatch = 0;
   int          check_count = 0;
   int          cycles = 0;
   int          seed = 11;
   logic [14:0] addrTab [6] = '{15'h0129, 15'h012A, 15'h01FF, 15'h0200, 15'h0201, 15'h7FFF};
   logic [7:0]  dcTab [4] = '{8'h00, 8'h01, 8'h03, 8'h0F};
   logic [5:0]  ratioTab [16] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h05, 6'h0A, 6'h0F,
                                  6'h03, 6'h06, 6'h0C, 6'h18, 6'h30, 6'h14, 6'h1E, 6'h28};
   // design and host
   csm_chip_sync_mode uut (.core_clk(core_clk), .srst(srst), .req(req), .rdata(rdata), .rvalid(rvalid),
      .clearCountBit(clr), .refIn(refIn), .sampleValid(sampleValid), .dividerReset(), .linkDrop(),
      .sampleMark(), .monitorRefPulse(), .downconverterEnable(dcEn), .inPhaseOnly(ionlyOut), .appMode(),
      .decimationCode(decCode), .decimationRatio(ratio));
   csm_host_model host (.core_clk(core_clk), .req(req));
   // compare and count
   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      expQ.push_back(e);
      host.access(1'b0, a, 8'h00);
   endtask : rd
   task automatic ev(input logic [3:0] ph);
      @(negedge core_clk);
      r = 8'($random(seed));
      sampleValid = r[0]; // random sample presence at the reference instant
      refIn = '{1'b1, ph};
      @(negedge core_clk);
      refIn = '{1'b0, ~ph};
   endtask : ev
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up
   // clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // read answers against the oldest note
   always @(negedge core_clk) begin
      if (rvalid === 1'b1) chk(expQ.pop_front(), rdata);
   end
   // hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // main sequence
   initial begin
      srst = 1'b1;
      clr = 1'b0;
      sampleValid = 1'b1;
      refIn = '0;
      repeat (5) @(negedge core_clk);
      srst = 1'b0;
      foreach (addrTab[i]) rd(addrTab[i], 8'h00);
      host.access(1'b1, 15'h01FF, 8'hFF);
      rd(15'h01FF, 8'h01);
      for (int i = 0; i < 258; i++) ev(i[3:0]);
      rd(15'h012A, 8'h02);
      rd(15'h0129, 8'h01);
      host.access(1'b1, 15'h01FF, 8'h00);
      clr = 1'b1;
      ev(4'hF);
      clr = 1'b0;
      rd(15'h012A, 8'h00);
      rd(15'h0129, 8'h0F);
      ev(4'h4);
      rd(15'h012A, 8'h01);
      host.access(1'b1, 15'h0200, 8'hFF);
      rd(15'h0200, 8'h2F);
      chk({7'h00, ionlyOut}, 8'h01);
      for (int c = 0; c < 4; c++) begin
         host.access(1'b1, 15'h0200, 8'(c));
         chk({4'h0, dcEn}, dcTab[c]);
      end
      for (int c = 0; c < 16; c++) begin
         r = 8'($random(seed));
         host.access(1'b1, 15'h0201, {r[7:4], c[3:0]});
         chk({2'h0, ratio}, {2'h0, ratioTab[c]});
         chk({4'h0, decCode}, {4'h0, c[3:0]});
         rd(15'h0201, {4'h0, c[3:0]});
      end
      repeat (4) @(negedge core_clk);
      wrap_up();
   end
endmodule : csm_chip_sync_mode_test
